// ---- rdf_pkg.sv ----
// Purpose: shared constants for the reverse data fifo control block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   printed offsets are register indexes; byte address is index times four
package rdf_pkg;
    // register indexes and byte addresses
    localparam logic [31:0] RDF_CTRL_IDX  = 32'h01ff823a;
    localparam logic [31:0] RDF_STAT_IDX  = 32'h01ff8240;
    localparam logic [31:0] RDF_MASK_IDX  = 32'h01ff8241;
    localparam logic [31:0] RDF_CTRL_ADDR = RDF_CTRL_IDX << 2;
    localparam logic [31:0] RDF_STAT_ADDR = RDF_STAT_IDX << 2;
    localparam logic [31:0] RDF_MASK_ADDR = RDF_MASK_IDX << 2;

    // control/status field positions
    localparam int RDF_ENABLED_BIT = 15;
    localparam int RDF_REQ_BIT     = 14;
    localparam int RDF_READY_BIT   = 13;
    localparam int RDF_THR_LSB     = 10;
    localparam int RDF_OUTPTR_LSB  = 8;
    localparam int RDF_HFULL_BIT   = 6;
    localparam int RDF_BPRES_BIT   = 5;
    localparam int RDF_QTY_LSB     = 2;
    localparam int RDF_INPTR_LSB   = 0;

    // interrupt status / mask bit positions
    localparam int RDF_EV_REQ = 0;
    localparam int RDF_EV_TC  = 1;
    localparam int RDF_EV_OVF = 2;
    localparam int RDF_EV_UDF = 3;
    localparam int RDF_NEV    = 4;

    // reset values and limits
    localparam logic [2:0]         RDF_THR_RST  = 3'h0;
    localparam logic [2:0]         RDF_THR_MAX  = 3'h4;
    localparam logic [2:0]         RDF_DEPTH    = 3'h4;
    localparam logic [1:0]         RDF_HOLD_TWO = 2'h2;
    localparam logic [RDF_NEV-1:0] RDF_MASK_RST = 4'h0;
endpackage : rdf_pkg

// ---- rdf_fill.sv ----
// Purpose: fill level, halfword slot pointers and holding register occupancy
// Assumes: hw_wr and byte_rd are one-cycle strobes from same-clock logic
// Notes:   the halfword data storage itself lives outside this module
`timescale 1ns/1ps
module rdf_fill
    import rdf_pkg::*;
(
    input  wire logic       hclk,         // system clock
    input  wire logic       hresetn,      // async reset, active low
    input  wire logic       en,           // fifo enabled
    input  wire logic       hw_wr,        // halfword written into fifo
    input  wire logic       byte_rd,      // byte taken by the port logic
    output logic [2:0]      qty,          // halfwords held, 0..4
    output logic [1:0]      in_ptr,       // next slot to write
    output logic [1:0]      out_ptr,      // next slot to read
    output logic            hold_full,    // two bytes in holding register
    output logic            byte_pres,    // one byte in holding register
    output logic            ovf,          // write refused, fifo full or off
    output logic            udf           // read with holding register empty
);
    typedef struct packed {
        logic [2:0] qty;
        logic [1:0] in_ptr;
        logic [1:0] out_ptr;
        logic [1:0] hold;
        logic       ovf;
        logic       udf;
    } rdf_fill_t;

    rdf_fill_t s_q, s_d;
    logic      acc_wr, load, take;

    always_comb begin
        acc_wr = en && hw_wr && (s_q.qty < RDF_DEPTH);
        load   = en && (s_q.hold == 2'h0) && (s_q.qty != 3'h0);
        take   = en && byte_rd && (s_q.hold != 2'h0);
        s_d     = s_q;
        s_d.ovf = hw_wr && !acc_wr;
        s_d.udf = byte_rd && !take;
        if (!en) begin
            s_d.qty     = 3'h0;
            s_d.in_ptr  = 2'h0;
            s_d.out_ptr = 2'h0;
            s_d.hold    = 2'h0;
        end else begin
            // quantity kept within 0..4
            if (acc_wr && !load) begin
                s_d.qty = s_q.qty + 3'h1;
            end else if (load && !acc_wr) begin
                s_d.qty = s_q.qty - 3'h1;
            end
            if (acc_wr) begin
                s_d.in_ptr = s_q.in_ptr + 2'h1;
            end
            if (load) begin
                s_d.out_ptr = s_q.out_ptr + 2'h1;
                s_d.hold    = RDF_HOLD_TWO;
            end else if (take) begin
                s_d.hold = s_q.hold - 2'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign qty       = s_q.qty;
    assign in_ptr    = s_q.in_ptr;
    assign out_ptr   = s_q.out_ptr;
    assign hold_full = (s_q.hold == RDF_HOLD_TWO);
    assign byte_pres = (s_q.hold == 2'h1);
    assign ovf       = s_q.ovf;
    assign udf       = s_q.udf;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_qty_step;
        en && hw_wr && (qty < RDF_DEPTH) && (s_q.hold != 2'h0) && en |=>
            (qty == $past(qty) + 3'h1) && (in_ptr == $past(in_ptr) + 2'h1);
    endproperty
    a_qty_step: assert property (p_qty_step)
        else $error("fill quantity or input pointer did not advance");

    property p_hold_load;
        en && (s_q.hold == 2'h0) && (qty != 3'h0) && !hw_wr |=>
            hold_full && (qty == $past(qty) - 3'h1);
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("holding register not loaded from fifo");
endmodule : rdf_fill

// ---- rdf_ctrl.sv ----
// Purpose: reverse data fifo control/status, dma request and interrupts
// Assumes: partner strobes and levels come from logic on hclk
// Notes:   AHB-Lite slave with zero wait states, response always OKAY
// Contract
// - the enabled bit follows the local enable, but stays set while a dma transfer is running.
// - the data-request bit shows the dma request, set when the threshold is met, cleared by terminal count.
// - once raised the request stays until removed, while dma or the processor services the fifo.
// - the request compares fill quantity against a 3-bit threshold of 1 to 4; zero gives no transfers.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module rdf_ctrl
    import rdf_pkg::*;
(
    input  wire logic        hclk,               // system clock
    input  wire logic        hresetn,            // async reset, active low
    input  wire logic        hsel,               // slave select
    input  wire logic [31:0] haddr,              // byte address
    input  wire logic [1:0]  htrans,             // transfer type
    input  wire logic        hwrite,             // write when high
    input  wire logic [2:0]  hsize,              // transfer size
    input  wire logic [31:0] hwdata,             // write data
    input  wire logic        hready,             // bus ready
    output logic             hreadyout,          // slave ready
    output logic             hresp,              // response, always okay
    output logic [31:0]      hrdata,             // read data
    input  wire logic        local_enable_input, // fifo enable from port logic
    input  wire logic        dma_busy,           // dma transfer executing
    input  wire logic        dma_terminal_count, // dma terminal count
    input  wire logic        hw_wr,              // halfword written by dma or cpu
    input  wire logic        byte_rd,            // byte taken by port logic
    output logic             dma_req,            // dma data request
    output logic             fifo_ready,         // fifo can accept a halfword
    output logic             irq                 // interrupt, active high level
);
    typedef struct packed {
        logic               en;
        logic [2:0]         thr;
        logic               req;
        logic               meet;
        logic [RDF_NEV-1:0] st;
        logic [RDF_NEV-1:0] mask;
        logic               wr_ctrl;
        logic               wr_mask;
        logic [31:0]        rdata;
    } rdf_ctrl_t;

    rdf_ctrl_t          s_q, s_d;
    logic [2:0]         qty;
    logic [1:0]         in_ptr, out_ptr;
    logic               hold_full, byte_pres, ovf, udf;
    logic               addr_ph, meet, rise, rd_stat;
    logic [15:0]        ctrl_word;
    logic [RDF_NEV-1:0] ev;

    rdf_fill u_fill (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .en        (s_q.en),
        .hw_wr     (hw_wr),
        .byte_rd   (byte_rd),
        .qty       (qty),
        .in_ptr    (in_ptr),
        .out_ptr   (out_ptr),
        .hold_full (hold_full),
        .byte_pres (byte_pres),
        .ovf       (ovf),
        .udf       (udf)
    );

    always_comb begin
        addr_ph = hsel && htrans[1] && hready;
        rd_stat = addr_ph && !hwrite && (haddr == RDF_STAT_ADDR);
        // threshold of zero or above four never matches
        meet = s_q.en && (s_q.thr != 3'h0) && (s_q.thr <= RDF_THR_MAX)
               && (qty >= s_q.thr);
        rise = meet && !s_q.meet;
        ctrl_word = 16'h0000;
        ctrl_word[RDF_ENABLED_BIT]                 = s_q.en;
        ctrl_word[RDF_REQ_BIT]                     = s_q.req;
        ctrl_word[RDF_READY_BIT]                   = fifo_ready;
        ctrl_word[RDF_THR_LSB +: 3]                = s_q.thr;
        ctrl_word[RDF_OUTPTR_LSB +: 2]             = out_ptr;
        ctrl_word[RDF_HFULL_BIT]                   = hold_full;
        ctrl_word[RDF_BPRES_BIT]                   = byte_pres;
        ctrl_word[RDF_QTY_LSB +: 3]                = qty;
        ctrl_word[RDF_INPTR_LSB +: 2]              = in_ptr;
        ev = '0;
        ev[RDF_EV_REQ] = rise;
        ev[RDF_EV_TC]  = dma_terminal_count;
        ev[RDF_EV_OVF] = ovf;
        ev[RDF_EV_UDF] = udf;

        s_d = s_q;
        // enable held through a running transfer
        if (local_enable_input) begin
            s_d.en = 1'b1;
        end else if (!dma_busy) begin
            s_d.en = 1'b0;
        end
        s_d.meet = meet;
        // set on reaching threshold, cleared by terminal count; set wins
        s_d.req = rise || (s_q.req && !dma_terminal_count);
        // read clears status; a new event in the same cycle survives
        s_d.st = rd_stat ? ev : (s_q.st | ev);
        // writes land in the data phase; threshold written on any control write, enabled or not
        if (s_q.wr_ctrl) begin
            s_d.thr = hwdata[RDF_THR_LSB +: 3];
        end
        if (s_q.wr_mask) begin
            s_d.mask = hwdata[RDF_NEV-1:0];
        end
        s_d.wr_ctrl = addr_ph && hwrite && (haddr == RDF_CTRL_ADDR);
        s_d.wr_mask = addr_ph && hwrite && (haddr == RDF_MASK_ADDR);
        if (addr_ph && !hwrite) begin
            unique case (haddr)
                RDF_CTRL_ADDR: s_d.rdata = {16'h0000, ctrl_word};
                RDF_STAT_ADDR: s_d.rdata = {{(32-RDF_NEV){1'b0}}, s_q.st};
                RDF_MASK_ADDR: s_d.rdata = {{(32-RDF_NEV){1'b0}}, s_q.mask};
                default:       s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q      <= '0;
            s_q.thr  <= RDF_THR_RST;
            s_q.mask <= RDF_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = s_q.rdata;
    assign dma_req    = s_q.req;
    assign fifo_ready = s_q.en && (qty < RDF_DEPTH);
    assign irq        = |(s_q.st & s_q.mask);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_en_follow;
        local_enable_input |=> s_q.en;
    endproperty
    a_en_follow: assert property (p_en_follow)
        else $error("enabled bit did not follow local enable");

    property p_en_hold;
        s_q.en && !local_enable_input && dma_busy |=> s_q.en;
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enabled bit dropped during a dma transfer");

    property p_en_drop;
        !local_enable_input && !dma_busy |=> !s_q.en;
    endproperty
    a_en_drop: assert property (p_en_drop)
        else $error("enabled bit stayed set after transfer ended");

    property p_req_clear;
        dma_req && dma_terminal_count && !rise |=> !dma_req;
    endproperty
    a_req_clear: assert property (p_req_clear)
        else $error("terminal count did not clear the request");

    property p_req_hold;
        dma_req && !dma_terminal_count |=> dma_req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before terminal count");

    property p_thr_zero;
        (s_q.thr == 3'h0) && !dma_req ##1 (s_q.thr == 3'h0) |-> !dma_req;
    endproperty
    a_thr_zero: assert property (p_thr_zero)
        else $error("request raised with threshold zero");

    property p_req_rise;
        s_q.en && (s_q.thr != 3'h0) && (s_q.thr <= RDF_THR_MAX)
            && (qty >= s_q.thr) && !s_q.meet |=> dma_req;
    endproperty
    a_req_rise: assert property (p_req_rise)
        else $error("request not raised at threshold");
endmodule : rdf_ctrl

// ---- rdf_dma_model.sv ----
// Purpose: dma channel model serving the fifo request
// Assumes: one clock; lat sets the service time
// Notes:   one terminal count pulse ends each service
`timescale 1ns/1ps
module rdf_dma_model (
    input  wire logic       hclk,               // clock
    input  wire logic       hresetn,            // reset, active low
    input  wire logic       dma_req,            // request
    input  wire logic [7:0] lat,                // service cycles
    output logic            dma_busy,           // transfer running
    output logic            dma_terminal_count  // transfer done
);
    logic [7:0] cnt_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q              <= 8'h00;
            dma_busy           <= 1'b0;
            dma_terminal_count <= 1'b0;
        end else begin
            dma_terminal_count <= dma_busy && cnt_q == 8'h00;
            if (!dma_busy && dma_req && !dma_terminal_count) begin
                dma_busy <= 1'b1;
                cnt_q    <= lat;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end else begin
                dma_busy <= 1'b0;
            end
        end
    end
endmodule : rdf_dma_model

// ---- tb_rdf_ctrl.sv ----
// Purpose: self-checking bench for the reverse fifo control
// Assumes: one slave, hready tied to hreadyout
// Notes:   port strobes come from here, dma from the model
`timescale 1ns/1ps
module tb_rdf_ctrl;
    import rdf_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic        loc_en, hw_wr, byte_rd, dma_req, fifo_ready, dma_busy, tc, rq;
    logic [31:0] haddr, hwdata, hrdata, r, e;
    logic [1:0]  htrans;
    logic [2:0]  hsize, q;
    logic [7:0]  lat;
    int          errors = 0;
    int          comparisons = 0;

    always #10 hclk = ~hclk;

    rdf_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .local_enable_input(loc_en), .dma_busy(dma_busy), .dma_terminal_count(tc),
        .hw_wr(hw_wr), .byte_rd(byte_rd), .dma_req(dma_req),
        .fifo_ready(fifo_ready), .irq(irq));
    rdf_dma_model dma (.hclk(hclk), .hresetn(hresetn), .dma_req(dma_req),
        .lat(lat), .dma_busy(dma_busy), .dma_terminal_count(tc));

    function automatic logic [31:0] ctrl_exp(logic en, logic rq, logic [2:0] th,
        logic [2:0] qt, logic [1:0] op, logic [1:0] ip, logic hf, logic bp);
        return {16'h0, en, rq, en && qt < 3'h4, th, op, 1'b0, hf, bp, qt, ip};
    endfunction : ctrl_exp

    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
        comparisons++;
        if (got !== x) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, x);
        end
    endtask : chk

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                chk(32'h0, 32'h1, "bus wait ran out");
                final_report();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        chk(32'(hresp), 32'h0, "response");
    endtask : bus

    task automatic rdc(input logic [31:0] x, input string m);
        bus(1'b0, RDF_CTRL_ADDR, 32'h0);
        chk(r, x, m);
    endtask : rdc

    task automatic pulse(input logic rd);
        hw_wr   <= !rd;
        byte_rd <= rd;
        @(posedge hclk);
        hw_wr   <= 1'b0;
        byte_rd <= 1'b0;
        repeat (2 + $urandom_range(2)) @(posedge hclk);
    endtask : pulse

    task automatic flush(input logic [2:0] t);
        loc_en <= 1'b0;
        bus(1'b1, RDF_CTRL_ADDR, ($urandom() & 32'hffff_e3ff) | {19'h0, t, 10'h0});
        loc_en <= 1'b1;
        @(posedge hclk);
    endtask : flush

    task automatic wait_idle;
        int n;
        n = 0;
        while ((dma_req !== 1'b0 || dma_busy !== 1'b0) && n < 300) begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (n >= 300) begin
            chk(32'h0, 32'h1, "dma wait ran out");
            final_report();
        end
    endtask : wait_idle

    initial begin
        {hclk, hresetn, hsel, hwrite, loc_en, hw_wr, byte_rd} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        lat = 8'd60;
        void'($urandom(44));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(32'h0, "reset value");
        bus(1'b0, RDF_MASK_ADDR, 32'h0);
        chk(r, 32'h0, "mask reset");
        bus(1'b0, 32'h0000_0100, 32'h0);
        chk(r, 32'h0, "unmapped");
        bus(1'b1, RDF_CTRL_ADDR, 32'hffff_ffff);
        rdc(ctrl_exp(1'b0, 1'b0, 3'h7, 3'h0, 2'h0, 2'h0, 1'b0, 1'b0), "thr only");
        $display("register test done");
        for (int t = 0; t <= 4; t++) begin
            lat <= 8'd60 + 8'($urandom_range(30));
            flush(3'(t));
            for (int k = 1; k <= 6; k++) begin
                pulse(1'b0);
                q = (k > 5) ? 3'h4 : 3'(k - 1);
                // quantity touches 1 before the first holding load
                rq = t != 0 && (q >= t || t == 1);
                e = ctrl_exp(1'b1, rq, 3'(t), q, 2'h1, 2'(q + 1), 1'b1, 1'b0);
                chk(32'(fifo_ready), 32'(q < 3'h4), "ready pin");
                rdc(e, "fill");
            end
            loc_en <= 1'b0;
            repeat (2) @(posedge hclk);
            bus(1'b0, RDF_CTRL_ADDR, 32'h0);
            chk(32'(r[15]), 32'(t != 0), "enable held");
            wait_idle();
            repeat (3) @(posedge hclk);
            #1 chk(32'(dma_req), 32'h0, "req after count");
            rdc(ctrl_exp(1'b0, 1'b0, 3'(t), 3'h0, 2'h0, 2'h0, 1'b0, 1'b0), "off");
            $display("threshold %0d test done", t);
        end
        flush(3'h0);
        bus(1'b1, RDF_MASK_ADDR, 32'(1 << RDF_EV_UDF));
        bus(1'b0, RDF_STAT_ADDR, 32'h0);
        chk(r, 32'(1 << RDF_EV_REQ | 1 << RDF_EV_TC | 1 << RDF_EV_OVF), "events");
        pulse(1'b1);
        #1 chk(32'(irq), 32'h1, "irq on underflow");
        bus(1'b0, RDF_STAT_ADDR, 32'h0);
        chk(r, 32'(1 << RDF_EV_UDF), "status");
        @(posedge hclk);
        #1 chk(32'(irq), 32'h0, "irq after read");
        bus(1'b1, RDF_MASK_ADDR, 32'h0);
        pulse(1'b1);
        #1 chk(32'(irq), 32'h0, "irq masked");
        $display("interrupt test done");
        pulse(1'b0);
        pulse(1'b0);
        pulse(1'b1);
        rdc(ctrl_exp(1'b1, 1'b0, 3'h0, 3'h1, 2'h1, 2'h2, 1'b0, 1'b1), "one byte");
        pulse(1'b1);
        rdc(ctrl_exp(1'b1, 1'b0, 3'h0, 3'h0, 2'h2, 2'h2, 1'b1, 1'b0), "reload");
        $display("byte test done");
        final_report();
    end
endmodule : tb_rdf_ctrl
